// >>> dpsem_port_ctrl.sv
// Host controller for one port of an asynchronous dual-port RAM with semaphores
//
// Function
// [RQ1] Master lets one port proceed, flags other
// [RQ2] Busy port's write is blocked internally
// [RQ3] Master: busy outputs; slave: write-inhibit inputs
// [RQ4] Slave system holds busy high normally
// [RQ5] Master busy outputs are push-pull
// [RQ6] Depth cascade ANDs busy indications together
// [RQ7] Width expansion uses exactly one master
// [RQ8] Arbitration uses enables and addresses only
// [RQ9] Hold address and enable before write pulse
// [RQ10] Eight semaphore latches in separate space
// [RQ11] Semaphore select low picks semaphore space
// [RQ12] Semaphore index from three low address bits
// [RQ13] Semaphore write uses data bit zero only
// [RQ14] Flags active low: write zero claims
// [RQ15] Claim shows zero here, one elsewhere
// [RQ16] Owner writing one frees or passes token
// [RQ17] Non-owner zero waits in request latch
// [RQ18] Both selects high puts port in standby
// [RQ19] Claim by write zero then read back (the controller issues no semaphore read)
// [RQ20] Flags do not gate array access
// [RQ21] Ports independent; same-location writes may conflict
// [RQ22] Semaphore read replicates flag onto all bits
// [RQ23] Semaphore read latched while select, enable low
// [RQ24] Master never flags both ports busy
// [RQ25] Simultaneous claims: exactly one side wins
// [RQ26] Busy released when match or enable ends
`timescale 1ns/10ps
module dpsem_port_ctrl
	import dpsem_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic req_valid,
	input wire req_t req,
	output logic req_ready,
	output logic rsp_valid,
	output rsp_t rsp,
	output pins_t pins,
	output logic [DATA_W-1:0] data_out,
	output logic data_oe_n,
	input wire logic [DATA_W-1:0] data_in,
	input wire logic busy_n,
	output logic standby
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SETUP = 3'h1,
		ST_PULSE = 3'h3,
		ST_HOLD = 3'h2,
		ST_DONE = 3'h6
	} state_t;

	state_t state_r;
	state_t state_nxt;
	req_t cur_r;
	logic [3:0] cnt_r;
	logic busy_n_s;
	logic [DATA_W-1:0] din_s;
	logic [DATA_W-1:0] rdata_r;
	logic stalled_r;
	req_t cur_nxt;
	logic in_access;

	// Decode that several processes need
	function automatic logic is_sem(input op_t op);
		return (op == OP_SEM_CLAIM) || (op == OP_SEM_RELEASE);
	endfunction

	function automatic logic is_write(input op_t op);
		return op != OP_MEM_READ;
	endfunction

	// Busy and read data come from the far device's pins
	// Busy is the single master's decision, ANDed outside when cascaded in depth;
	// a strap held high simply never stalls us
	pin_sync #(.W(1)) u_busy_sync (
		.clk(clk),
		.resetn(resetn),
		.d(busy_n), // [RQ4] [RQ6] [RQ7]
		.q(busy_n_s)
	);

	pin_sync #(.W(DATA_W)) u_data_sync (
		.clk(clk),
		.resetn(resetn),
		.d(data_in),
		.q(din_s)
	);

	assign req_ready = (state_r == ST_IDLE);

	// Sequencer; a claim is the write half of write-then-read, and no request reads the semaphore back
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (req_valid) begin
					state_nxt = ST_SETUP;
				end
			end
			ST_SETUP: begin
				// Address and enable settle until busy is decided, and a memory access stalls while busy [RQ9]
				if (cnt_r == CNT_ZERO && (busy_n_s || is_sem(cur_r.op))) begin
					state_nxt = ST_PULSE;
				end
			end
			ST_PULSE: begin
				if (cnt_r == CNT_ZERO) begin
					state_nxt = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (cnt_r == CNT_ZERO) begin
					state_nxt = ST_DONE;
				end
			end
			ST_DONE: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Phase counter reloads on each state change
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= CNT_ZERO;
		end else if (state_r != state_nxt) begin
			unique case (state_nxt)
				ST_SETUP: cnt_r <= 4'(SETUP_CYC + SYNC_CYC - 1); // [RQ9]
				ST_PULSE: cnt_r <= 4'(PULSE_CYC - 1);
				ST_HOLD: cnt_r <= 4'(HOLD_CYC - 1);
				default: cnt_r <= CNT_ZERO;
			endcase
		end else if (cnt_r != CNT_ZERO) begin
			cnt_r <= cnt_r - 4'h1;
		end
	end

	// Request in force: the one being taken this edge, else the latched one
	// Pins are driven from this, so the first setup cycle already shows the new access
	always_comb begin
		cur_nxt = cur_r;
		if (req_valid && req_ready) begin
			cur_nxt = req;
			if (is_sem(req.op)) begin
				cur_nxt.addr = {{(ADDR_W-SEM_IDX_W){1'b0}}, req.addr[SEM_IDX_W-1:0]}; // [RQ12]
				cur_nxt.wdata = {{(DATA_W-1){1'b0}}, req.op == OP_SEM_RELEASE}; // [RQ13] [RQ14]
			end
		end
	end

	// Latch request; semaphore index uses only three low bits, data only bit zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cur_r <= '0;
		end else begin
			cur_r <= cur_nxt;
		end
	end

	// Either select is low from the taking edge until the answer
	assign in_access = (state_nxt != ST_IDLE) && (state_nxt != ST_DONE);

	// Stall seen if busy was ever low during setup of a memory access
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stalled_r <= 1'b0;
		end else if (state_r == ST_IDLE) begin
			stalled_r <= 1'b0;
		end else if (state_r == ST_SETUP && !busy_n_s && !is_sem(cur_r.op)) begin
			stalled_r <= 1'b1; // [RQ1] [RQ26]
		end
	end

	// Sample read data at the end of hold; the synchroniser needs the whole pulse to
	// agree on the driven word, so sampling at pulse end would take the stale value
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_r <= DATA_RST;
		end else if (state_r == ST_HOLD && cnt_r == CNT_ZERO && !is_write(cur_r.op)) begin
			rdata_r <= din_s;
		end
	end

	// Pin drive; selects return high between cycles; output enable falls only for memory reads [RQ23]
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pins <= '{chip_enable_n: 1'b1, semaphore_select_n: 1'b1, output_enable_n: 1'b1,
				write_n: 1'b1, addr: ADDR_RST};
			data_out <= DATA_RST;
			data_oe_n <= 1'b1;
		end else begin
			pins.chip_enable_n <= !(in_access && !is_sem(cur_nxt.op));
			pins.semaphore_select_n <= !(in_access && is_sem(cur_nxt.op)); // [RQ11]
			pins.output_enable_n <= !((state_nxt == ST_PULSE) && !is_write(cur_nxt.op));
			pins.write_n <= !((state_nxt == ST_PULSE) && is_write(cur_nxt.op)); // [RQ9]
			pins.addr <= cur_nxt.addr;
			data_out <= cur_nxt.wdata;
			data_oe_n <= !((state_nxt == ST_PULSE || state_nxt == ST_HOLD) && is_write(cur_nxt.op));
		end
	end

	// Both selects high between accesses lets the port power down [RQ18]
	assign standby = pins.chip_enable_n && pins.semaphore_select_n;

	// Answer: granted means a memory read returned bit zero low [RQ19] [RQ22]
	assign rsp_valid = (state_r == ST_DONE);
	always_comb begin
		rsp.rdata = rdata_r;
		rsp.stalled = stalled_r;
		// Writes and semaphore ops carry no grant of their own
		rsp.granted = 1'b0;
		if (!is_write(cur_r.op)) begin
			rsp.granted = ~rdata_r[0];
		end
	end
endmodule

// >>> dpsem_pkg.sv
// Package: constants and carrier types for the dual-port semaphore controller
package dpsem_pkg;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 18;
	localparam int SEM_IDX_W = 3;
	localparam int SEM_CNT = 8;
	// Bus cycle timing at 200 MHz
	localparam int CLK_PERIOD_PS = 5000;
	localparam int SETUP_TIME_PS = 10000;
	localparam int PULSE_TIME_PS = 20000;
	localparam int HOLD_TIME_PS = 5000;
	localparam int SETUP_CYC = (SETUP_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PULSE_CYC = (PULSE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int HOLD_CYC = (HOLD_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Edges for a pin change to pass the three-flop synchroniser and be agreed
	localparam int SYNC_CYC = 4;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;

	typedef enum logic [1:0] {
		OP_MEM_READ = 2'h0,
		OP_MEM_WRITE = 2'h1,
		OP_SEM_CLAIM = 2'h2,
		OP_SEM_RELEASE = 2'h3
	} op_t;

	typedef struct packed {
		op_t op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} req_t;

	typedef struct packed {
		logic chip_enable_n;
		logic semaphore_select_n;
		logic output_enable_n;
		logic write_n;
		logic [ADDR_W-1:0] addr;
	} pins_t;

	typedef struct packed {
		logic granted;
		logic stalled;
		logic [DATA_W-1:0] rdata;
	} rsp_t;
endpackage

// >>> pin_sync.sv
// Three-flop input synchroniser; a change counts once stages two and three agree
`timescale 1ns/10ps
module pin_sync
	import dpsem_pkg::*;
#(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	// Stage one feeds stage two only
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1_r <= '1;
			s2_r <= '1;
			s3_r <= '1;
			q <= '1;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (int i = 0; i < W; i++) begin
				if (s2_r[i] == s3_r[i]) begin
					q[i] <= s3_r[i];
				end
			end
		end
	end
endmodule

// >>> dpsem_port_ctrl_monitor.sv
// Checker for the port controller's pin sequencing
`timescale 1ns/10ps
module dpsem_port_ctrl_monitor
	import dpsem_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic req_valid,
	input wire req_t req,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire rsp_t rsp,
	input wire pins_t pins,
	input wire logic [DATA_W-1:0] data_out,
	input wire logic data_oe_n,
	input wire logic [DATA_W-1:0] data_in,
	input wire logic busy_n,
	input wire logic standby
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Either select low; the strobe may only fall after two cycles of it
	wire logic sel_lo = !pins.chip_enable_n || !pins.semaphore_select_n;
	a_setup_before_strobe: assert property ($fell(pins.write_n) |-> $past(sel_lo) && $past(sel_lo, 2))
		else $error("write strobe fell without address setup");
	a_strobe_width: assert property ($fell(pins.write_n) |-> !pins.write_n [*4] ##1 pins.write_n)
		else $error("write strobe width wrong");
	a_data_held_pulse: assert property (!pins.write_n |-> !data_oe_n && $stable(pins.addr))
		else $error("address or data not held during strobe");
	a_sem_addr_mask: assert property (!pins.semaphore_select_n |-> pins.addr[12:3] == 10'h000)
		else $error("semaphore access with high address bits set");
	a_one_space: assert property (!(!pins.chip_enable_n && !pins.semaphore_select_n))
		else $error("memory and semaphore selected together");
	a_answer_time: assert property (req_valid && req_ready ##0 busy_n [*8] |-> ##5 rsp_valid)
		else $error("answer late with busy high");
	a_standby_answer: assert property (rsp_valid |-> standby)
		else $error("port not in standby at the answer");
	cover property (rsp_valid && rsp.stalled);
	cover property (rsp_valid && rsp.granted);
	cover property ($fell(pins.write_n) && !pins.semaphore_select_n);
	cover property (!pins.output_enable_n && !pins.chip_enable_n);
endmodule
bind dpsem_port_ctrl dpsem_port_ctrl_monitor mon (.clk(clk), .resetn(resetn), .req_valid(req_valid),
	.req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .data_out(data_out),
	.data_oe_n(data_oe_n), .data_in(data_in), .busy_n(busy_n), .standby(standby));

// >>> dpsem_dev_model.sv
// Behavioural model of one port of the dual-port RAM with its semaphores
`timescale 1ns/10ps
module dpsem_dev_model
	import dpsem_pkg::*;
(
	input wire logic clk,
	input wire pins_t pins,
	input wire logic [DATA_W-1:0] data_out,
	input wire logic data_oe_n,
	input wire logic other_ce_n,
	input wire logic [ADDR_W-1:0] other_addr,
	input wire logic other_we,
	input wire logic [SEM_IDX_W-1:0] other_idx,
	input wire logic other_d,
	output logic [DATA_W-1:0] data_in,
	output logic busy_n,
	output logic [SEM_CNT-1:0] own_l
);
	logic [DATA_W-1:0] mem [2**ADDR_W];
	logic [SEM_CNT-1:0] req_l = '0, req_r = '0, own_r = '0;
	logic [DATA_W-1:0] last_r = '0, sem_lat = '1;
	wire logic [SEM_IDX_W-1:0] idx = pins.addr[SEM_IDX_W-1:0];
	wire logic sem_rd = !pins.semaphore_select_n && !pins.output_enable_n;
	wire logic mem_rd = !pins.chip_enable_n && !pins.output_enable_n;
	initial own_l = '0;
	// Far side is always the earlier one, so only this port is flagged; push-pull, never floats
	// Strapped as master, so busy is an output here
	assign busy_n = !(!pins.chip_enable_n && !other_ce_n && pins.addr == other_addr);
	// Released or standby bus toggles so a late sample cannot pass by luck
	assign data_in = sem_rd ? sem_lat : mem_rd ? mem[pins.addr] : ~last_r;
	// Array and semaphore latches; flags never gate the array
	always @(posedge clk) begin
		last_r <= data_in;
		if (!sem_rd) sem_lat <= {DATA_W{!own_l[idx]}};
		if (!pins.write_n && !pins.chip_enable_n && busy_n) mem[pins.addr] <= data_out;
		if (!pins.write_n && !pins.semaphore_select_n) req_l[idx] <= !data_out[0];
		if (other_we) req_r[other_idx] <= !other_d;
		// Holder keeps the token; a tie goes to this side
		own_l <= req_l & ~(own_r & req_r);
		own_r <= req_r & ~(req_l & ~(own_r & req_r));
	end
endmodule

// >>> test_dpsem_port_ctrl.sv
// Self-checking bench for the port controller against the device model
`timescale 1ns/10ps
module test_dpsem_port_ctrl
	import dpsem_pkg::*;
;
	typedef struct packed {op_t op; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d; logic [DATA_W-1:0] e;} row_t;
	logic clk = 0, resetn = 0, req_valid = 0, req_ready, rsp_valid, data_oe_n, busy_n, standby;
	logic other_ce_n = 1, other_we = 0, other_d = 1;
	logic [SEM_IDX_W-1:0] other_idx = '0;
	logic [ADDR_W-1:0] other_addr = '0;
	logic [SEM_CNT-1:0] own_l;
	logic [DATA_W-1:0] data_out, data_in;
	req_t req = '0;
	rsp_t rsp;
	pins_t pins;
	int error_cnt = 0, check_count = 0, n;
	// Reads expect data, semaphore ops expect the token bit
	row_t rows [8] = '{'{OP_MEM_WRITE, 13'h0005, 18'h2A5C3, 18'h00000}, '{OP_MEM_READ, 13'h0005, 18'h00000, 18'h2A5C3},
		'{OP_MEM_WRITE, 13'h1FFF, 18'h3FFFE, 18'h00000}, '{OP_MEM_READ, 13'h1FFF, 18'h00000, 18'h3FFFE},
		'{OP_SEM_CLAIM, 13'h1FFB, 18'h3FFFE, 18'h00001}, '{OP_SEM_RELEASE, 13'h0003, 18'h00001, 18'h00000},
		'{OP_SEM_CLAIM, 13'h0007, 18'h00000, 18'h00001}, '{OP_SEM_RELEASE, 13'h0007, 18'h00001, 18'h00000}};
	dpsem_port_ctrl uut (.clk(clk), .resetn(resetn), .req_valid(req_valid), .req(req), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .data_out(data_out), .data_oe_n(data_oe_n),
		.data_in(data_in), .busy_n(busy_n), .standby(standby));
	dpsem_dev_model dev (.clk(clk), .pins(pins), .data_out(data_out), .data_oe_n(data_oe_n),
		.other_ce_n(other_ce_n), .other_addr(other_addr), .other_we(other_we), .other_idx(other_idx),
		.other_d(other_d), .data_in(data_in), .busy_n(busy_n), .own_l(own_l));
	initial forever #2.5 clk = ~clk;
	task give_verdict;
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	// One request, held over the taking edge, then a bounded wait for the answer
	task run(input op_t op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(negedge clk);
		req_valid = 1;
		req = '{op, a, d};
		@(negedge clk);
		req_valid = 0;
		n = 0;
		while (rsp_valid !== 1'b1 && n <= 200) begin
			@(negedge clk);
			n++;
		end
		// A hang counts once and the flow runs on to the closing report
		if (rsp_valid !== 1'b1) begin
			error_cnt++;
			$display("MISMATCH rsp_valid expected 1 seen 0");
		end
	endtask
	// Far-side semaphore write, one cycle long
	task other_sem(input logic [SEM_IDX_W-1:0] i, input logic d);
		@(negedge clk);
		other_idx = i;
		other_d = d;
		other_we = 1;
		@(negedge clk);
		other_we = 0;
		@(negedge clk);
	endtask
	initial begin
		repeat (10) @(negedge clk);
		chk("reset pins", {1'b0, 4'hF, ADDR_RST}, {1'b0, pins});
		chk("reset idle", 18'h00002, {16'h0, req_ready, rsp_valid} | {17'h0, ~data_oe_n});
		resetn = 1;
		for (int i = 0; i < 8; i++) begin
			run(rows[i].op, rows[i].a, rows[i].d);
			chk("no stall", 18'h0, {17'h0, rsp.stalled});
			chk("standby", 18'h1, {17'h0, standby});
			if (rows[i].op == OP_MEM_READ) begin
				chk("rdata", rows[i].e, rsp.rdata);
				chk("granted", {17'h0, ~rows[i].e[0]}, {17'h0, rsp.granted});
			end else if (rows[i].op != OP_MEM_WRITE) begin
				chk("token", rows[i].e, {17'h0, own_l[rows[i].a[2:0]]});
			end
		end
		// Far side holds the token: our claim waits, then passes over on its release
		other_sem(3'h2, 1'b0);
		run(OP_SEM_CLAIM, 13'h0002, 18'h00000);
		chk("pending", 18'h0, {17'h0, own_l[2]});
		other_sem(3'h2, 1'b1);
		chk("handover", 18'h1, {17'h0, own_l[2]});
		run(OP_SEM_RELEASE, 13'h0002, 18'h00001);
		chk("freed", 18'h0, {17'h0, own_l[2]});
		// Reset in mid-strobe: pins fall back to idle at once and the next access works
		@(negedge clk);
		req_valid = 1;
		req = '{OP_MEM_WRITE, 13'h0100, 18'h0F0F0};
		@(negedge clk);
		req_valid = 0;
		repeat (8) @(negedge clk);
		chk("mid strobe", 18'h0, {17'h0, pins.write_n});
		resetn = 0;
		@(negedge clk);
		chk("mid reset pins", {1'b0, 4'hF, ADDR_RST}, {1'b0, pins});
		chk("mid reset idle", 18'h00002, {16'h0, req_ready, rsp_valid});
		resetn = 1;
		run(OP_MEM_WRITE, 13'h0100, 18'h0F0F0);
		run(OP_MEM_READ, 13'h0100, 18'h00000);
		chk("after reset", 18'h0F0F0, rsp.rdata);
		// Contention: write stalls until the far side drops its enable
		other_addr = 13'h0040;
		other_ce_n = 0;
		fork
			run(OP_MEM_WRITE, 13'h0040, 18'h15555);
			begin
				repeat (20) @(negedge clk);
				other_ce_n = 1;
			end
		join
		chk("stalled", 18'h1, {17'h0, rsp.stalled && n > 20});
		run(OP_MEM_READ, 13'h0040, 18'h00000);
		chk("after stall", 18'h15555, rsp.rdata);
		give_verdict;
	end
endmodule
